// ---- rtl/adc_register_control.sv ----
// Digital control and 8-bit register interface of the eight-channel 10-bit converter
// Overview of operation
// (RULE1) A result is 10 bits: top eight in bits 15..8, low two in bits 7..6.
// (RULE2) The six low bits of each result low byte always read zero.
// (RULE3) Channels 0/4 go to result A, 1/5 to B, 2/6 to C, 3/7 to D.
// (RULE4) All result registers clear to zero on reset and in standby.
// (RULE5) The control/status register clears to zero on reset and in standby.
// (RULE6) End flag sets after a single conversion or after a full scan pass.
// (RULE7) Software clears the end flag only by writing zero after reading it as one.
// (RULE8) A DMA access to a result register, started by the end request, clears the flag.
// (RULE9) The end request is raised only while the interrupt enable bit is one.
// (RULE10) Run bit reads one while converting; single mode clears it at the end.
// (RULE11) Scan mode repeats the selected channels until the run bit is cleared.
// (RULE12) Bit 4 picks single or scan; change it only while stopped.
// (RULE13) Bit 3 picks speed: at most 266 or at most 134 states per conversion.
// (RULE14) Top select bit picks group; low two pick one channel or the scan count.
// (RULE15) Trigger control register starts as 0x7f on reset and in standby.
// (RULE16) With external start enabled, a falling trigger edge sets the run bit.
// (RULE17) With external start disabled, the trigger pin is ignored.
// (RULE18) The seven low trigger control bits read one; software writes ones.
// (RULE19) Reading a result high byte also copies its low byte into a holding latch.
// (RULE20) Reading a result low byte returns the holding latch, not the live byte.
// (RULE21) Software reads the high byte before the low byte for a consistent value.
// (RULE22) A scan starts at the group's first channel; next follows right after each end.
// (RULE23) Scan conversions after the first take 256 or 128 states.
// (RULE24) A result is stored in the done cycle, before the end flag updates.
`timescale 1ns/100ps
`default_nettype none
module adc_register_control
   import adc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic standby,
   input wire logic bus_sel,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [3:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_dma,
   output logic [7:0] bus_rdata,
   input wire logic external_start_pin_n,
   input wire logic [9:0] core_result,
   output logic core_start,
   output logic [2:0] core_channel,
   output logic core_sample,
   output logic conversion_end_request
);
   import adc_pkg::*;

   // Notes for users of this block:
   // - Standby behaves as a held reset, so every register reads its reset value after it.
   // - Writing the run bit as zero stops a conversion at once; no result is stored then.
   // - The first conversion after a start always takes the longest time, so software
   //   sees the same latency whatever the phase of the start.
   // - Scan repeats add one finish state between conversions to update the flag.
   // - The trigger pin passes two flip-flops, so an external start lags by a few cycles.
   // - The holding latch is shared by all four results; an upper byte read of another
   //   result between the two halves of a word read spoils the low byte.
   // - Mode, speed and channel should only be changed while the run bit is zero.
   // - Writing one to the run bit while running keeps the run going; it does not restart.
   // - Reads of unused offsets return zero; writes to them and to the results are ignored.
   // - The end request follows flag and enable one cycle late and is a level.
   // - Result low bytes reach the bus only through the holding latch.
   // - The analog core must hold its result steady until the done cycle.

   // Sequencer state, state counter and scan position
   adc_state_e state_q, state_d;
   logic [8:0] cnt_q;
   logic [1:0] scan_idx_q;
   logic go_q;

   // Stored results and the byte holding latch
   logic [15:0] result_q [4];
   logic [7:0] hold_q;

   // Control/status and trigger control bits
   logic end_flag_q, end_ie_q, run_q, scan_q, speed_q;
   logic [2:0] chan_sel_q;
   logic ext_en_q;
   logic flag_seen_q;

   // Trigger pin synchroniser and edge history
   logic [1:0] trig_sync_q;
   logic trig_prev_q;

   // Registered outputs and the read data that feeds them
   logic [7:0] rdata_d;
   logic core_start_q;
   logic [2:0] core_channel_q;
   logic core_sample_q;
   logic req_q;

   // Bus decode
   logic init;
   logic rd, wr;
   logic csr_wr, trig_wr, csr_rd;
   logic hi_rd, any_result;

   // Sequencer and flag events
   logic ext_fall, start_now, stop_now;
   logic start_first, start_next;
   logic conv_done, pass_done;
   logic flag_set, flag_sw_clr, flag_dma_clr;
   logic [1:0] cur_reg;
   logic [8:0] conv_len;
   logic load_speed;
   logic [7:0] csr_val, trig_val;

   // Result register index of a byte address (address bits 2..1)
   function automatic logic [1:0] reg_of(input logic [3:0] a);
      reg_of = a[2:1];
   endfunction

   // Format a raw conversion as the stored 16-bit word
   function automatic logic [15:0] pack_result(input logic [9:0] r);
      pack_result = {r, 6'h00}; // [RULE1] [RULE2]
   endfunction

   // Byte address holds the upper byte of one of the four results
   function automatic logic is_hi_addr(input logic [3:0] a);
      is_hi_addr = !a[3] && !a[0];
   endfunction

   // Byte address falls in the result window
   function automatic logic is_result_addr(input logic [3:0] a);
      is_result_addr = !a[3];
   endfunction

   // Standby acts as a held reset of every register
   assign init = !rst_n || standby; // [RULE4] [RULE5] [RULE15]
   assign rd = bus_sel && bus_rd;
   assign wr = bus_sel && bus_wr;
   assign csr_wr = wr && (bus_addr == ADC_OFF_CTRL_STATUS);
   assign trig_wr = wr && (bus_addr == ADC_OFF_TRIG_CTRL);
   assign csr_rd = rd && (bus_addr == ADC_OFF_CTRL_STATUS);
   assign hi_rd = rd && is_hi_addr(bus_addr);
   assign any_result = bus_sel && is_result_addr(bus_addr);

   // Trigger edge looks only at synchronised samples, never the first stage
   assign ext_fall = ext_en_q && trig_prev_q && !trig_sync_q[1]; // [RULE16] [RULE17]
   assign start_now = (csr_wr && bus_wdata[ADC_BIT_RUN] && !run_q) || (ext_fall && !run_q);
   assign stop_now = csr_wr && !bus_wdata[ADC_BIT_RUN];

   // Start events: a new run, or the next channel of a scan; a start written together
   // with new settings must take the written speed, not the one still stored
   assign start_first = (state_q == ADC_IDLE) && start_now;
   assign start_next = (state_q == ADC_FINISH) && (state_d == ADC_CONVERT);
   assign load_speed = csr_wr ? bus_wdata[ADC_BIT_SPEED] : speed_q; // [RULE13]

   // Conversion length: the first conversion after a start takes the maximum so that the
   // latency does not depend on the phase of the start; scan repeats are fixed
   assign conv_len = (state_q == ADC_IDLE) ?
                     (load_speed ? ADC_CNT_FAST_FIRST : ADC_CNT_SLOW_FIRST) :
                     (load_speed ? ADC_CNT_FAST_NEXT : ADC_CNT_SLOW_NEXT); // [RULE13] [RULE23]
   assign conv_done = (state_q == ADC_CONVERT) && (cnt_q == 9'h001);
   assign cur_reg = scan_q ? scan_idx_q : chan_sel_q[1:0]; // [RULE14]
   assign pass_done = !scan_q || (scan_idx_q == chan_sel_q[1:0]); // [RULE6]

   // End flag events; the set is given priority over both clears
   assign flag_set = (state_q == ADC_FINISH) && pass_done && !stop_now; // [RULE6] [RULE24]
   assign flag_sw_clr = csr_wr && flag_seen_q && !bus_wdata[ADC_BIT_END_FLAG]; // [RULE7]
   assign flag_dma_clr = any_result && bus_dma && req_q; // [RULE8]

   assign csr_val = {end_flag_q, end_ie_q, run_q, scan_q, speed_q, chan_sel_q};
   assign trig_val = {ext_en_q, ADC_TRIG_ONES}; // [RULE18]

   // Read data decode
   always_comb begin
      rdata_d = 8'h00;
      if (bus_addr == ADC_OFF_CTRL_STATUS) begin
         rdata_d = csr_val;
      end else if (bus_addr == ADC_OFF_TRIG_CTRL) begin
         rdata_d = trig_val;
      end else if (is_hi_addr(bus_addr)) begin
         rdata_d = result_q[reg_of(bus_addr)][15:8];
      end else if (is_result_addr(bus_addr)) begin
         rdata_d = hold_q; // [RULE20] [RULE21]
      end
   end

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ADC_IDLE: begin
            if (start_now) begin
               state_d = ADC_CONVERT;
            end
         end
         ADC_CONVERT: begin
            if (stop_now) begin
               state_d = ADC_IDLE;
            end else if (conv_done) begin
               state_d = ADC_FINISH;
            end
         end
         ADC_FINISH: begin
            if (stop_now || !scan_q) begin
               state_d = ADC_IDLE;
            end else begin
               state_d = ADC_CONVERT; // [RULE11] [RULE22]
            end
         end
         default: state_d = ADC_IDLE;
      endcase
   end

   // Trigger pin synchroniser and edge history
   // The reset value matches the idle high pin, so no false edge follows reset
   always_ff @(posedge mclk) begin
      if (init) begin
         trig_sync_q <= 2'b11;
         trig_prev_q <= 1'b1;
      end else begin
         trig_sync_q <= {trig_sync_q[0], external_start_pin_n};
         trig_prev_q <= trig_sync_q[1];
      end
   end

   // Sequencer state, state counter and scan position
   always_ff @(posedge mclk) begin
      if (init) begin
         state_q <= ADC_IDLE;
         cnt_q <= 9'h000;
         scan_idx_q <= 2'b00;
      end else begin
         state_q <= state_d;
         if (start_first) begin
            // A new scan always begins at the group's first channel
            scan_idx_q <= 2'b00; // [RULE22]
            cnt_q <= conv_len;
         end else if (state_q == ADC_FINISH) begin
            // Wrap to the first channel once the last selected one is done
            scan_idx_q <= pass_done ? 2'b00 : scan_idx_q + 2'b01;
            cnt_q <= conv_len;
         end else if (state_q == ADC_CONVERT && cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 9'h001;
         end
      end
   end

   // Result storage on the done cycle
   // A stopped conversion stores nothing, so a half-finished result never lands
   generate
      for (genvar i = 0; i < 4; i++) begin : g_res
         always_ff @(posedge mclk) begin
            if (init) begin
               result_q[i] <= ADC_RESULT_RST; // [RULE4]
            end else if (conv_done && !stop_now && cur_reg == 2'(i)) begin
               result_q[i] <= pack_result(core_result); // [RULE3] [RULE24]
            end
         end
      end
   endgenerate

   // Holding latch filled by a high byte read
   always_ff @(posedge mclk) begin
      if (init) begin
         hold_q <= 8'h00;
      end else if (hi_rd) begin
         hold_q <= result_q[reg_of(bus_addr)][7:0]; // [RULE19]
      end
   end

   // Control/status bits; end flag set wins over every clear
   always_ff @(posedge mclk) begin
      if (init) begin
         end_flag_q <= ADC_CSR_RST[ADC_BIT_END_FLAG]; // [RULE5]
         end_ie_q <= ADC_CSR_RST[ADC_BIT_END_IE];
         run_q <= ADC_CSR_RST[ADC_BIT_RUN];
         scan_q <= ADC_CSR_RST[ADC_BIT_SCAN];
         speed_q <= ADC_CSR_RST[ADC_BIT_SPEED];
         chan_sel_q <= ADC_CSR_RST[2:0];
         flag_seen_q <= 1'b0;
      end else begin
         // A read of the flag as one arms the software clear; any write disarms it
         if (csr_rd && end_flag_q) begin
            flag_seen_q <= 1'b1;
         end else if (csr_wr) begin
            flag_seen_q <= 1'b0;
         end
         // Writing one to the flag is ignored; only the events below move it
         if (flag_set) begin
            end_flag_q <= 1'b1; // [RULE6] [RULE24]
         end else if (flag_sw_clr) begin
            end_flag_q <= 1'b0; // [RULE7]
         end else if (flag_dma_clr) begin
            end_flag_q <= 1'b0; // [RULE8]
         end
         if (csr_wr) begin
            end_ie_q <= bus_wdata[ADC_BIT_END_IE];
            scan_q <= bus_wdata[ADC_BIT_SCAN]; // [RULE12]
            speed_q <= bus_wdata[ADC_BIT_SPEED];
            chan_sel_q <= bus_wdata[2:0];
         end
         // Any write loads the run bit from the data; a trigger edge sets it
         if (csr_wr || ext_fall) begin
            run_q <= (csr_wr && bus_wdata[ADC_BIT_RUN]) || ext_fall; // [RULE10] [RULE16]
         end else if (state_q == ADC_FINISH && !scan_q) begin
            run_q <= 1'b0; // [RULE10]
         end
      end
   end

   // Trigger control register; low bits are constant ones
   always_ff @(posedge mclk) begin
      if (init) begin
         ext_en_q <= ADC_TRIG_RST[ADC_BIT_EXT_EN]; // [RULE15]
      end else if (trig_wr) begin
         ext_en_q <= bus_wdata[ADC_BIT_EXT_EN];
      end
   end

   // Registered outputs to bus and analog core
   always_ff @(posedge mclk) begin
      if (init) begin
         bus_rdata <= 8'h00;
         go_q <= 1'b0;
         core_start_q <= 1'b0;
         core_channel_q <= 3'h0;
         core_sample_q <= 1'b0;
         req_q <= 1'b0;
      end else begin
         bus_rdata <= rd ? rdata_d : 8'h00;
         // The start pulse lags the event by two cycles so that the channel beside it
         // already shows settings written together with the run bit
         go_q <= start_first || start_next;
         core_start_q <= go_q;
         core_channel_q <= {chan_sel_q[ADC_BIT_GROUP], cur_reg};
         core_sample_q <= conv_done && !stop_now;
         req_q <= end_flag_q && end_ie_q; // [RULE9]
      end
   end

   assign core_start = core_start_q;
   assign core_channel = core_channel_q;
   assign core_sample = core_sample_q;
   assign conversion_end_request = req_q;
endmodule
`default_nettype wire

// ---- rtl/adc_pkg.sv ----
// Package of register offsets, bit fields, reset values and timing counts for the converter control
package adc_pkg;
   localparam logic [3:0] ADC_OFF_RESULT_A_HI = 4'h0;
   localparam logic [3:0] ADC_OFF_RESULT_A_LO = 4'h1;
   localparam logic [3:0] ADC_OFF_RESULT_B_HI = 4'h2;
   localparam logic [3:0] ADC_OFF_RESULT_B_LO = 4'h3;
   localparam logic [3:0] ADC_OFF_RESULT_C_HI = 4'h4;
   localparam logic [3:0] ADC_OFF_RESULT_C_LO = 4'h5;
   localparam logic [3:0] ADC_OFF_RESULT_D_HI = 4'h6;
   localparam logic [3:0] ADC_OFF_RESULT_D_LO = 4'h7;
   localparam logic [3:0] ADC_OFF_CTRL_STATUS = 4'h8;
   localparam logic [3:0] ADC_OFF_TRIG_CTRL = 4'h9;
   // Control/status and trigger control bit positions
   localparam int ADC_BIT_END_FLAG = 7;
   localparam int ADC_BIT_END_IE = 6;
   localparam int ADC_BIT_RUN = 5;
   localparam int ADC_BIT_SCAN = 4;
   localparam int ADC_BIT_SPEED = 3;
   localparam int ADC_BIT_GROUP = 2;
   localparam int ADC_BIT_EXT_EN = 7;
   localparam int ADC_RESULT_W = 10;
   localparam logic [15:0] ADC_RESULT_RST = 16'h0000;
   localparam logic [7:0] ADC_CSR_RST = 8'h00;
   localparam logic [7:0] ADC_TRIG_RST = 8'h7f;
   localparam logic [6:0] ADC_TRIG_ONES = 7'h7f;
   // Conversion times in states (one state is one mclk cycle)
   localparam int ADC_CONV_SLOW_MAX = 266;
   localparam int ADC_CONV_FAST_MAX = 134;
   localparam int ADC_CONV_SLOW_SCAN = 256;
   localparam int ADC_CONV_FAST_SCAN = 128;
   localparam logic [8:0] ADC_CNT_SLOW_FIRST = 9'(ADC_CONV_SLOW_MAX);
   localparam logic [8:0] ADC_CNT_FAST_FIRST = 9'(ADC_CONV_FAST_MAX);
   localparam logic [8:0] ADC_CNT_SLOW_NEXT = 9'(ADC_CONV_SLOW_SCAN);
   localparam logic [8:0] ADC_CNT_FAST_NEXT = 9'(ADC_CONV_FAST_SCAN);
   typedef enum logic [1:0] {ADC_IDLE, ADC_CONVERT, ADC_FINISH} adc_state_e;
endpackage

// ---- dv/adc_properties.sv ----
// Port-level checks of bus answers and conversion timing
`timescale 1ns/100ps
`default_nettype none
module adc_props (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic standby,
   input wire logic bus_sel,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [3:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   input wire logic core_start,
   input wire logic core_sample,
   input wire logic conversion_end_request
);
   logic [8:0] gap_q;
   wire rd = bus_sel && bus_rd;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n || standby);
   // Cycles since the last start; saturates so a lost start still shows
   always_ff @(posedge mclk) begin
      if (!rst_n || core_start) gap_q <= 9'h000;
      else if (gap_q != 9'h1ff) gap_q <= gap_q + 9'h001;
   end
   AST_LO_ZERO: assert property (
      rd && !bus_addr[3] && bus_addr[0] |=> bus_rdata[5:0] == 6'h00)
      else $error("low byte spare bits set");
   AST_TRIG_ONES: assert property (
      rd && bus_addr == 4'h9 |=> bus_rdata[6:0] == 7'h7f)
      else $error("trigger spare bits not one");
   AST_RST_QUIET: assert property (disable iff (1'b0)
      !rst_n |=> bus_rdata == 8'h00 && !conversion_end_request)
      else $error("outputs active after reset");
   AST_SBY_QUIET: assert property (disable iff (1'b0)
      standby |=> !core_start && !core_sample && bus_rdata == 8'h00)
      else $error("outputs active after standby");
   AST_IE_OFF: assert property (
      bus_sel && bus_wr && bus_addr == 4'h8 && !bus_wdata[6] |=> ##1 !conversion_end_request)
      else $error("request with enable off");
   AST_CONV_TIME: assert property (
      core_sample |-> gap_q >= 9'h078 && gap_q <= 9'h10e)
      else $error("conversion time out of range");
   AST_START_PULSE: assert property (
      core_start |=> !core_start)
      else $error("start pulse too long");
   AST_ONE_STORE: assert property (
      core_sample |=> !core_sample)
      else $error("result stored twice");
   // Main scenarios reached
   COV_SAMPLE: cover property (core_sample);
   COV_REQ: cover property ($rose(conversion_end_request));
   COV_TRIG_RD: cover property (rd && bus_addr == 4'h9);
endmodule
bind adc_register_control adc_props u_props (.mclk(mclk), .rst_n(rst_n), .standby(standby),
   .bus_sel(bus_sel), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr),
   .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .core_start(core_start),
   .core_sample(core_sample), .conversion_end_request(conversion_end_request));
`default_nettype wire

// ---- dv/adc_core_model.sv ----
// Behavioural analog core answering each start with a channel-coded result
`timescale 1ns/100ps
`default_nettype none
module adc_core_model (
   input wire logic mclk,
   input wire logic core_start,
   input wire logic [2:0] core_channel,
   output var logic [9:0] core_result
);
   initial core_result = 10'h000;
   // Result encodes the channel, so a store into the wrong register shows up
   always @(posedge mclk) begin
      if (core_start) core_result <= {core_channel, ~core_channel, 2'h2, core_channel[1:0]};
   end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import adc_pkg::*;
   typedef struct {logic [3:0] addr; logic [7:0] exp;} adc_row_s;
   logic mclk = 1'b0, rst_n = 1'b0, standby = 1'b0, trig_n = 1'b1, bus_dma = 1'b0;
   logic bus_sel = 1'b0, bus_rd = 1'b0, bus_wr = 1'b0;
   logic [3:0] bus_addr = 4'h0;
   logic [7:0] bus_wdata = 8'h00;
   logic [7:0] bus_rdata;
   logic [9:0] core_result;
   logic [2:0] core_channel;
   logic core_start, core_sample, conversion_end_request;
   int mismatches = 0, comparisons = 0, cycles = 0;
   adc_row_s rows [11] = '{'{4'h0, 8'h00}, '{4'h1, 8'h00}, '{4'h2, 8'h00}, '{4'h3, 8'h00},
      '{4'h4, 8'h00}, '{4'h5, 8'h00}, '{4'h6, 8'h00}, '{4'h7, 8'h00}, '{4'h8, 8'h00},
      '{4'h9, 8'h7f}, '{4'ha, 8'h00}};
   always #2 mclk = ~mclk;
   adc_register_control uut (.mclk(mclk), .rst_n(rst_n), .standby(standby), .bus_sel(bus_sel),
      .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_dma(bus_dma), .bus_rdata(bus_rdata), .external_start_pin_n(trig_n),
      .core_result(core_result), .core_start(core_start), .core_channel(core_channel),
      .core_sample(core_sample), .conversion_end_request(conversion_end_request));
   adc_core_model core (.mclk(mclk), .core_start(core_start), .core_channel(core_channel),
      .core_result(core_result));
   // Expected bytes of the coded result that the core model returns
   function automatic logic [7:0] hi(input logic [2:0] c);
      return {c, ~c, 2'h2};
   endfunction
   function automatic logic [7:0] lo(input logic [2:0] c);
      return {c[1:0], 6'h00};
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One byte access; for a read, d is the byte expected back a cycle later
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus_sel <= 1'b1;
      bus_wr <= w;
      bus_rd <= !w;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge mclk);
      bus_sel <= 1'b0;
      bus_wr <= 1'b0;
      bus_rd <= 1'b0;
      #1;
      if (!w) check(bus_rdata, d);
   endtask
   // Counts stored results; the cycle ceiling cuts a hang short
   task automatic wait_ev(input int n);
      int k;
      k = 0;
      while (k < n) begin
         @(posedge mclk);
         if (core_sample === 1'b1) k++;
      end
      repeat (2) @(posedge mclk);
   endtask
   task automatic pulse_trig;
      @(posedge mclk);
      trig_n <= 1'b0;
      repeat (4) @(posedge mclk);
      trig_n <= 1'b1;
      repeat (6) @(posedge mclk);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         end_sim();
      end
   end
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      foreach (rows[i]) acc(1'b0, rows[i].addr, rows[i].exp);
      $display("reset values done");
      acc(1'b1, 4'h8, 8'h69);
      wait_ev(1);
      check({7'h00, conversion_end_request}, 8'h01);
      acc(1'b0, 4'h8, 8'hc9);
      acc(1'b1, 4'h8, 8'hc9);
      acc(1'b0, 4'h8, 8'hc9);
      acc(1'b1, 4'h8, 8'h49);
      acc(1'b0, 4'h8, 8'h49);
      acc(1'b0, 4'h2, hi(3'h1));
      acc(1'b0, 4'h3, lo(3'h1));
      $display("single conversion done");
      acc(1'b1, 4'h8, 8'h35);
      wait_ev(2);
      check({7'h00, conversion_end_request}, 8'h00);
      acc(1'b0, 4'h8, 8'hb5);
      acc(1'b0, 4'h0, hi(3'h4));
      acc(1'b0, 4'h3, lo(3'h4));
      acc(1'b0, 4'h2, hi(3'h5));
      acc(1'b0, 4'h3, lo(3'h5));
      acc(1'b1, 4'h8, 8'h15);
      acc(1'b0, 4'h8, 8'h15);
      $display("scan done");
      pulse_trig();
      acc(1'b0, 4'h8, 8'h15);
      acc(1'b1, 4'h8, 8'h55);
      acc(1'b1, 4'h9, 8'hff);
      acc(1'b0, 4'h9, 8'hff);
      pulse_trig();
      acc(1'b0, 4'h8, 8'h75);
      wait_ev(2);
      bus_dma <= 1'b1;
      acc(1'b0, 4'h0, hi(3'h4));
      @(posedge mclk);
      bus_dma <= 1'b0;
      acc(1'b0, 4'h8, 8'h75);
      $display("trigger and dma done");
      @(posedge mclk);
      standby <= 1'b1;
      @(posedge mclk);
      standby <= 1'b0;
      acc(1'b0, 4'h8, 8'h00);
      acc(1'b0, 4'h9, 8'h7f);
      acc(1'b0, 4'h0, 8'h00);
      $display("standby done");
      end_sim();
   end
endmodule
`default_nettype wire
